// ===== verilog/twc_ctrl_slave.sv
// three-wire control port slave: start-up, address, control and status.
// assumes pins come straight from the package balls; core signals are on
// mclk_i; item payload handling lives in the decoder core.
`timescale 1ns/1ps
`default_nettype none
`include "twc_regs.svh"

module twc_ctrl_slave
   import twc_pkg::*;
(
   // system
   input  wire logic       mclk_i,
   input  wire logic       srst_i,
   // three-wire control pins
   input  wire logic       ctl_bit_clock_i,
   input  wire logic       ctl_addr_data_select_i,
   input  wire logic       ctl_serial_data_i,
   output logic            ctl_serial_data_o,
   output logic            ctl_serial_data_oe_o,
   // decoder core state
   input  wire logic       frame_start_i,
   input  wire logic [1:0] decode_phase_i,
   input  wire logic       input_locked_i,
   input  wire logic       item_ready_i,
   // item transfer side
   output logic            item_start_o,
   output logic            item_resume_o,
   output logic [7:0]      item_code_o,
   output logic [7:0]      control_word_o,
   output logic            item_wr_o,
   output logic [7:0]      item_wdata_o,
   input  wire logic [7:0] item_rdata_i,
   output logic            item_rd_next_o
);

   logic [2:0] sync_w;
   twc_pins_t  pins_s;
   twc_pins_t  prev_q;
   twc_init_t  init_q;
   twc_mode_t  mode_q;
   logic       hit_q;
   logic [2:0] cnt_q;
   logic [7:0] sh_q;
   logic [7:0] tx_q;
   logic [7:0] saved_q;
   logic       ctrl_seen_q;
   logic       oe_q;
   logic [7:0] status_w;
   twc_core_t  core_w;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers; clock idles high and select low during reset
   twc_pin_sync #(
      .W   (3),
      .RST (`TWC_PIN_RST)
   ) u_sync (
      .mclk_i  (mclk_i),
      .srst_i  (srst_i),
      .async_i ({ctl_bit_clock_i, ctl_addr_data_select_i, ctl_serial_data_i}),
      .sync_o  (sync_w)
   );

   assign pins_s = sync_w;

   // previous pin levels for edge detection
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         prev_q <= `TWC_PIN_RST;
      end else begin
         prev_q <= pins_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // edge and phase decode
   logic clk_rise_w;
   logic clk_fall_w;
   logic sel_edge_w;
   logic run_w;
   logic byte_done_w;
   logic [7:0] rx_w;
   logic addr_done_w;
   logic addr_hit_w;
   logic data_done_w;
   logic rd_mode_w;

   assign clk_rise_w  = pins_s.clk & ~prev_q.clk;
   assign clk_fall_w  = ~pins_s.clk & prev_q.clk;
   assign sel_edge_w  = pins_s.sel ^ prev_q.sel;
   assign run_w       = (init_q == TWC_RUN);
   assign byte_done_w = run_w & clk_rise_w & ~sel_edge_w & (cnt_q == 3'h7);
   assign rx_w        = {pins_s.dat, sh_q[7:1]};         // lsb first
   assign addr_done_w = byte_done_w & ~pins_s.sel;
   assign addr_hit_w  = (rx_w[7:2] == `TWC_ADDR_TAG);
   assign data_done_w = byte_done_w & pins_s.sel & hit_q;
   assign rd_mode_w   = (mode_q == TWC_RD_ITEM) | (mode_q == TWC_RD_STAT);

   ////////////////////////////////////////////////////////////////////////
   // start-up: select must go high then low before the port listens;
   // anything clocked earlier is dropped, protecting other bus users
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         init_q <= TWC_INIT_HI;
      end else begin
         unique case (init_q)
            TWC_INIT_HI: if (pins_s.sel) init_q <= TWC_INIT_LO;
            TWC_INIT_LO: if (!pins_s.sel) init_q <= TWC_RUN;
            TWC_RUN:     init_q <= TWC_RUN;
            default:     init_q <= TWC_INIT_HI;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bit counter and receive shifter; a select edge starts a new byte
   always_ff @(posedge mclk_i) begin
      if (srst_i || !run_w || sel_edge_w) begin
         cnt_q <= 3'h0;
      end else if (clk_rise_w) begin
         cnt_q <= 3'(cnt_q + 3'h1);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         sh_q <= 8'h00;
      end else if (run_w && clk_rise_w) begin
         sh_q <= rx_w;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // address phase: match latches the mode until the next address phase
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         hit_q  <= 1'b0;
         mode_q <= TWC_WR_CTRL;
      end else if (addr_done_w) begin
         hit_q <= addr_hit_w;
         if (addr_hit_w) begin
            mode_q <= twc_mode_t'(rx_w[1:0]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control byte decode; no ready gating, so control is taken at any
   // time and each byte overwrites the last
   logic ctrl_take_w;
   logic code_item_w;
   logic code_resume_w;

   assign ctrl_take_w   = data_done_w & (mode_q == TWC_WR_CTRL);
   assign code_item_w   = (rx_w <= `TWC_CC_COEF) & (rx_w != `TWC_CC_RSVD4);
   assign code_resume_w = (rx_w == `TWC_CC_RESUME);

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         control_word_o <= `TWC_CTRL_RST;
         ctrl_seen_q    <= 1'b0;
      end else if (ctrl_take_w) begin
         control_word_o <= rx_w;
         ctrl_seen_q    <= 1'b1;
      end
   end

   // item state; reserved codes fall through and change nothing
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         item_code_o <= `TWC_CC_SETTINGS;
         saved_q     <= `TWC_CC_SETTINGS;
      end else if (ctrl_take_w && code_item_w) begin
         item_code_o <= rx_w;
         if (rx_w == `TWC_CC_COEF && item_code_o != `TWC_CC_COEF) begin
            saved_q <= item_code_o;   // remember what coefficients interrupt
         end
      end else if (ctrl_take_w && code_resume_w) begin
         item_code_o <= saved_q;
      end
   end

   // one-cycle strobes towards the core
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         item_start_o   <= 1'b0;
         item_resume_o  <= 1'b0;
         item_wr_o      <= 1'b0;
         item_rd_next_o <= 1'b0;
      end else begin
         item_start_o   <= ctrl_take_w & code_item_w;
         item_resume_o  <= ctrl_take_w & code_resume_w;
         item_wr_o      <= data_done_w & (mode_q == TWC_WR_ITEM);
         item_rd_next_o <= data_done_w & (mode_q == TWC_RD_ITEM);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         item_wdata_o <= 8'h00;
      end else if (data_done_w && mode_q == TWC_WR_ITEM) begin
         item_wdata_o <= rx_w;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status byte
   assign core_w = '{frame_start: frame_start_i, phase: decode_phase_i,
                     locked: input_locked_i, item_ready: item_ready_i};

   twc_status u_status (
      .mclk_i      (mclk_i),
      .srst_i      (srst_i),
      .core_i      (core_w),
      .ctrl_seen_i (ctrl_seen_q),
      .status_o    (status_w)
   );

   ////////////////////////////////////////////////////////////////////////
   // transmit shifter; reloaded every cycle between bytes so repeated
   // status reads are fresh and bit 0 (ready) sits on the line for polling.
   // item data is passed as the core holds it, valid or not
   logic tx_load_w;

   assign tx_load_w = run_w & pins_s.sel & hit_q & rd_mode_w & (cnt_q == 3'h0);

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         tx_q <= 8'h00;
      end else if (tx_load_w) begin
         tx_q <= (mode_q == TWC_RD_STAT) ? status_w
                                         : item_rdata_i;
      end else if (clk_fall_w && cnt_q != 3'h0) begin
         tx_q <= {1'b0, tx_q[7:1]};
      end
   end

   // drive only in an addressed read data phase; undriven in reset
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= run_w & pins_s.sel & hit_q & rd_mode_w;
      end
   end

   assign ctl_serial_data_o    = tx_q[0];
   assign ctl_serial_data_oe_o = oe_q;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (srst_i);

   ctrl_replace_a : assert property (ctrl_take_w |=> control_word_o == $past(rx_w))
      else $error("control byte not stored");

   item_start_a : assert property (ctrl_take_w && code_item_w
      |=> item_start_o && item_code_o == $past(rx_w))
      else $error("item start code not taken");

   resume_item_a : assert property (ctrl_take_w && code_resume_w
      |=> item_resume_o && item_code_o == $past(saved_q))
      else $error("resume did not restore item");

   reserved_keep_a : assert property (ctrl_take_w && !code_item_w && !code_resume_w
      |=> !item_start_o && $stable(item_code_o))
      else $error("reserved code changed item state");

   addr_mode_a : assert property (addr_done_w && addr_hit_w
      |=> hit_q && mode_q == twc_mode_t'($past(rx_w[1:0])))
      else $error("address hit did not set mode");

   ignore_data_a : assert property (!hit_q ##1 !hit_q |-> !oe_q && !item_wr_o)
      else $error("unaddressed device acted on data");

   poll_ready_a : assert property (tx_load_w && mode_q == TWC_RD_STAT
      |=> ctl_serial_data_o == $past(status_w[`TWC_ST_RDY]))
      else $error("ready bit not on data line");

   ctrl_any_a : assert property (ctrl_take_w |=> ctrl_seen_q)
      else $error("control byte refused");

   cov_ctrl_c   : cover property (ctrl_take_w ##[1:200] ctrl_take_w);
   cov_status_c : cover property (oe_q && mode_q == TWC_RD_STAT ##[1:400] data_done_w);
   cov_resume_c : cover property (item_resume_o);
   cov_wr_c     : cover property (item_wr_o);

endmodule

`default_nettype wire

// ===== include/twc_regs.svh
// constants of the three-wire control slave: address tag, decode phase code,
// control codes, status bit positions and reset values.
// assumes it is included by bare name from the design files.
`ifndef TWC_REGS_SVH
`define TWC_REGS_SVH

// address phase: upper six bits that select this device
`define TWC_ADDR_TAG     6'h18

// control codes
`define TWC_CC_SETTINGS  8'h00
`define TWC_CC_HDR_DEC   8'h01
`define TWC_CC_HDR_USED  8'h02
`define TWC_CC_ERR_REP   8'h03
`define TWC_CC_RSVD4     8'h04
`define TWC_CC_ANCIL     8'h05
`define TWC_CC_COEF      8'h06
`define TWC_CC_RESUME    8'h07

// status byte bit positions
`define TWC_ST_PARITY    7
`define TWC_ST_PHASE_HI  6
`define TWC_ST_PHASE_LO  5
`define TWC_ST_LOCK      1
`define TWC_ST_RDY       0

// decode phase code of sample decoding
`define TWC_PH_SAMPLES   2'h3

// reset values
`define TWC_CTRL_RST     8'h00
`define TWC_STATUS_RST   8'h00
`define TWC_PIN_RST      3'h4

`endif

// ===== include/twc_pkg.sv
// types of the three-wire control slave.
// assumes nothing beyond a SystemVerilog compiler.
package twc_pkg;

   // data operation mode, order follows the two low address bits
   typedef enum logic [1:0] {
      TWC_WR_ITEM,
      TWC_RD_ITEM,
      TWC_WR_CTRL,
      TWC_RD_STAT
   } twc_mode_t;

   // start-up sequence after device reset
   typedef enum logic [1:0] {
      TWC_INIT_HI,
      TWC_INIT_LO,
      TWC_RUN
   } twc_init_t;

   // the three control pins after synchronisation
   typedef struct packed {
      logic clk;
      logic sel;
      logic dat;
   } twc_pins_t;

   // state reported by the decoder core
   typedef struct packed {
      logic       frame_start;
      logic [1:0] phase;
      logic       locked;
      logic       item_ready;
   } twc_core_t;

endpackage

// ===== verilog/twc_pin_sync.sv
// two-flop synchronisers for the control pins.
// assumes pins are asynchronous to mclk_i; reset value per bit from RST.
`timescale 1ns/1ps
`default_nettype none

module twc_pin_sync #(
   parameter int unsigned    W   = 3,
   parameter logic [W-1:0]   RST = '0
) (
   // system
   input  wire logic         mclk_i,
   input  wire logic         srst_i,
   // pins in, synchronised out
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);

   logic [W-1:0] meta_q;

   ////////////////////////////////////////////////////////////////////////
   // one synchroniser per pin; meta_q feeds only the second stage
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk_i) begin
         if (srst_i) begin
            meta_q[i] <= RST[i];
            sync_o[i] <= RST[i];
         end else begin
            meta_q[i] <= async_i[i];
            sync_o[i] <= meta_q[i];
         end
      end
   end

endmodule

`default_nettype wire

// ===== verilog/twc_status.sv
// status byte builder: frame parity counter, phase, lock and ready.
// assumes core inputs are on mclk_i; frame_start is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
`include "twc_regs.svh"

module twc_status
   import twc_pkg::*;
(
   // system
   input  wire logic      mclk_i,
   input  wire logic      srst_i,
   // core state and control history
   input  wire twc_core_t core_i,
   input  wire logic      ctrl_seen_i,
   // status byte
   output logic [7:0]     status_o
);

   logic parity_q;
   logic ready_w;
   logic lock_w;

   ////////////////////////////////////////////////////////////////////////
   // modulo 2 frame counter
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         parity_q <= 1'b0;
      end else if (core_i.frame_start) begin
         parity_q <= ~parity_q;
      end
   end

   // ready held low until a control byte arrives after reset
   assign ready_w = ctrl_seen_i & core_i.item_ready;
   assign lock_w  = core_i.locked;

   ////////////////////////////////////////////////////////////////////////
   // byte refreshed every cycle; parity and phase are zeroed while
   // unlocked so the host never sees stale frame state.
   // the phase is passed as the core reports it; the core owns the
   // minimum length of sample decoding.
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         status_o <= `TWC_STATUS_RST;
      end else begin
         status_o <= '0;
         status_o[`TWC_ST_PARITY]   <= parity_q & lock_w;
         status_o[`TWC_ST_PHASE_HI] <= core_i.phase[1] & lock_w;
         status_o[`TWC_ST_PHASE_LO] <= core_i.phase[0] & lock_w;
         status_o[`TWC_ST_LOCK]     <= lock_w;
         status_o[`TWC_ST_RDY]      <= ready_w;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   parity_flip_a : assert property (@(posedge mclk_i) disable iff (srst_i)
      core_i.frame_start |=> parity_q != $past(parity_q))
      else $error("frame parity did not invert on frame start");

   ready_gate_a : assert property (@(posedge mclk_i) disable iff (srst_i)
      !ctrl_seen_i ##1 !ctrl_seen_i |-> !status_o[`TWC_ST_RDY])
      else $error("ready shown before first control byte");

   phase_lock_a : assert property (@(posedge mclk_i) disable iff (srst_i)
      !$past(srst_i) && $past(core_i.locked) |-> status_o[6:5] == $past(core_i.phase))
      else $error("status phase differs from core phase");

endmodule

`default_nettype wire

// ===== verif/twc_host_model.sv
// host model: drives bit clock and select, shares the serial data wire.
// assumes the device syncs the pins itself; bit clock period is 400 ns.
`timescale 1ns/1ps
`default_nettype none

module twc_host_model (
   // device side of the data wire
   input  wire logic dev_d_i,
   input  wire logic dev_oe_i,
   // bus pins
   output logic      bclk_o,
   output logic      sel_o,
   output logic      wire_o
);
   logic host_d;
   logic host_oe;
   logic last;

   ////////////////////////////////////////////////////////////
   // a released line shows the inverse of its last level, so
   // a device that reads it early never sees a lucky value
   always @(dev_d_i or dev_oe_i or host_d or host_oe) begin
      if (dev_oe_i) last = dev_d_i;
      else if (host_oe) last = host_d;
   end
   assign wire_o = dev_oe_i ? dev_d_i : (host_oe ? host_d : ~last);

   // idle bus while reset is held: clock high, select low
   initial begin
      bclk_o = 1'b1;
      sel_o = 1'b0;
      host_d = 1'b0;
      host_oe = 1'b0;
      last = 1'b0;
   end

   // change select with the clock high, then let it settle
   task automatic set_sel(input logic v);
      sel_o = v;
      #400;
   endtask

   // one byte lsb first; the host samples just before each rise
   task automatic xfer(input logic drv, input logic [7:0] w, output logic [7:0] r);
      for (int i = 0; i < 8; i++) begin
         bclk_o = 1'b0;
         host_oe = drv;
         host_d = w[i];
         #200;
         r[i] = wire_o;
         bclk_o = 1'b1;
         #200;
      end
      host_oe = 1'b0;
   endtask
endmodule

`default_nettype wire

// ===== verif/three_wire_control_slave_test.sv
// testbench of the three-wire control slave with a host model.
// assumes 20 MHz mclk_i and the host model on the far side of the pins.
`timescale 1ns/1ps
`default_nettype none

module three_wire_control_slave_test;
   logic       mclk_i;
   logic       srst_i;
   logic       bclk;
   logic       sel;
   logic       dwire;
   logic       dout;
   logic       doe;
   logic       fstart;
   logic [1:0] ph;
   logic       locked;
   logic       rdy;
   logic       istart;
   logic       iresume;
   logic [7:0] icode;
   logic [7:0] cword;
   logic       iwr;
   logic [7:0] iwdata;
   logic [7:0] irdata;
   logic       ird_next;
   int         n_fail;
   int         cmp_count;
   int         n_start;
   int         n_res;
   int         n_wr;
   int         n_rd;
   logic [7:0] r;
   logic [7:0] exp_code;
   logic       par;
   logic [7:0] codes [9];

   ////////////////////////////////////////////////////////////
   twc_ctrl_slave u_twc_ctrl_slave (
      .mclk_i(mclk_i), .srst_i(srst_i), .ctl_bit_clock_i(bclk),
      .ctl_addr_data_select_i(sel), .ctl_serial_data_i(dwire),
      .ctl_serial_data_o(dout), .ctl_serial_data_oe_o(doe),
      .frame_start_i(fstart), .decode_phase_i(ph), .input_locked_i(locked),
      .item_ready_i(rdy), .item_start_o(istart), .item_resume_o(iresume),
      .item_code_o(icode), .control_word_o(cword), .item_wr_o(iwr),
      .item_wdata_o(iwdata), .item_rdata_i(irdata), .item_rd_next_o(ird_next));

   twc_host_model u_twc_host_model (
      .dev_d_i(dout), .dev_oe_i(doe), .bclk_o(bclk), .sel_o(sel), .wire_o(dwire));

   // clock
   initial begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end

   // pulse counters, since pulses last only one cycle
   always @(posedge mclk_i) begin
      if (istart === 1'b1) n_start++;
      if (iresume === 1'b1) n_res++;
      if (iwr === 1'b1) n_wr++;
      if (ird_next === 1'b1) n_rd++;
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("unexpected %s: expected %h seen %h", what, e, g);
         n_fail++;
      end
   endtask

   // address phase with select low, then select high for data
   task automatic addr(input logic [7:0] a);
      u_twc_host_model.set_sel(1'b0);
      u_twc_host_model.xfer(1'b1, a, r);
      u_twc_host_model.set_sel(1'b1);
   endtask

   // write one data byte and let the answer land
   task automatic put(input logic [7:0] b);
      u_twc_host_model.xfer(1'b1, b, r);
      repeat (4) @(posedge mclk_i);
      #2;
   endtask

   task automatic get(output logic [7:0] v);
      u_twc_host_model.xfer(1'b0, 8'h00, v);
   endtask

   // hang guard
   initial begin
      repeat (100000) @(posedge mclk_i);
      n_fail++;
      close_out();
   end

   ////////////////////////////////////////////////////////////
   initial begin
      srst_i = 1'b1;
      fstart = 1'b0;
      ph = 2'h3;
      locked = 1'b0;
      rdy = 1'b1;
      irdata = 8'h3c;
      codes = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'hff};
      repeat (4) @(posedge mclk_i);
      #2;
      srst_i = 1'b0;
      check("oe in reset", 8'h00, {7'h00, doe});
      check("control word", 8'h00, cword);
      u_twc_host_model.set_sel(1'b1);
      u_twc_host_model.set_sel(1'b0);
      // first access is a status read, before any control byte
      addr(8'h63);
      check("ready poll", 8'h00, {7'h00, dwire});
      get(r);
      check("status", 8'h00, r);
      // codes 00 to 06, 08 and ff back to back, no ready poll in between
      addr(8'h62);
      exp_code = 8'h00;
      foreach (codes[i]) begin
         n_start = 0;
         put(codes[i]);
         if (codes[i] < 8'h07 && codes[i] != 8'h04) exp_code = codes[i];
         check("control word", codes[i], cword);
         check("start count", {7'h00, (codes[i] < 8'h07 && codes[i] != 8'h04)}, n_start[7:0]);
         check("item code", exp_code, icode);
      end
      // interrupt an item with the coefficient write, then resume
      put(8'h03);
      put(8'h06);
      n_res = 0;
      put(8'h07);
      check("resume count", 8'h01, n_res[7:0]);
      check("item code", 8'h03, icode);
      // repeated status reads while the core walks its phases
      locked = 1'b1;
      par = 1'b0;
      addr(8'h63);
      check("ready poll", 8'h01, {7'h00, dwire});
      for (int p = 0; p < 4; p++) begin
         @(posedge mclk_i);
         #2;
         ph = 2'(p);
         fstart = 1'b1;
         @(posedge mclk_i);
         #2;
         fstart = 1'b0;
         par = ~par;
         repeat (4) @(posedge mclk_i);
         #2;
         get(r);
         check("status", {par, 2'(p), 3'h0, 2'h3}, r);
      end
      rdy = 1'b0;
      locked = 1'b0;
      repeat (4) @(posedge mclk_i);
      #2;
      get(r);
      check("status", 8'h00, r);
      // another device's address: data phases are ignored
      addr(8'h22);
      n_start = 0;
      put(8'h01);
      check("control word", 8'h07, cword);
      check("start count", 8'h00, n_start[7:0]);
      addr(8'h23);
      check("oe", 8'h00, {7'h00, doe});
      // item write after ready is seen, then item read
      rdy = 1'b1;
      addr(8'h63);
      get(r);
      check("ready bit", 8'h01, {7'h00, r[0]});
      addr(8'h60);
      n_wr = 0;
      put(8'ha5);
      check("write count", 8'h01, n_wr[7:0]);
      check("write data", 8'ha5, iwdata);
      addr(8'h61);
      n_rd = 0;
      get(r);
      check("item read", 8'h3c, r);
      repeat (4) @(posedge mclk_i);
      #2;
      check("read next count", 8'h01, n_rd[7:0]);
      u_twc_host_model.set_sel(1'b0);
      close_out();
   end
endmodule

`default_nettype wire
